/* hdl/smst_top.sv */
// Supply and ground monitor self-test control with Avalon-MM registers.
// Assumes analog trip inputs are asynchronous and active high, and that
// the analog monitors honour the inject and monitor-on outputs.
`timescale 1ns/10ps
`default_nettype none

module smst_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Analog monitor side
   input wire logic [11:0] i_monitor_trip,
   output logic [11:0] o_monitor_on,
   output logic [11:0] o_selftest_inject,
   // Flags and interrupt
   output logic [11:0] o_fault_flags,
   output logic o_irq
);

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_m_r;
   logic rst_n_r;

   // Asynchronous assert, two-flop release
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_m_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n_r <= rst_m_r;
      end
   end

   // ************************************************************
   // Register storage
   // ************************************************************
   logic [15:0] selftest_r;
   logic [15:0] selftest_nxt;
   logic [15:0] mon_on_r;
   logic [15:0] mon_on_nxt;
   logic [15:0] status_r;
   logic [15:0] status_nxt;
   logic [15:0] mask_r;
   logic [15:0] mask_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   smst_pkg::smst_bus_state_t state_r;
   smst_pkg::smst_bus_state_t state_nxt;

   // ************************************************************
   // Trip input synchronisers
   // ************************************************************
   logic [11:0] trip_s1_r;
   logic [11:0] trip_s2_r;
   logic [11:0] trip_s3_r;
   logic [11:0] trip_f_r;
   logic [11:0] trip_f_nxt;

   // Take the new level only where stages two and three agree
   assign trip_f_nxt = (trip_s2_r & trip_s3_r) |
      (trip_f_r & (trip_s2_r ^ trip_s3_r));

   // Three-flop chain plus filtered level
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         trip_s1_r <= 12'h000;
         trip_s2_r <= 12'h000;
         trip_s3_r <= 12'h000;
         trip_f_r <= 12'h000;
      end else begin
         trip_s1_r <= i_monitor_trip;
         trip_s2_r <= trip_s1_r;
         trip_s3_r <= trip_s2_r;
         trip_f_r <= trip_f_nxt;
      end
   end

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire req = i_avs_read | i_avs_write;
   wire in_answer = (state_r == smst_pkg::SMST_ANSWER);
   wire wr_commit = i_avs_write & in_answer;
   wire rd_take = i_avs_read & ~in_answer;
   wire hit_selftest = (i_avs_address == smst_pkg::ADDR_SELFTEST);
   wire hit_mon_on = (i_avs_address == smst_pkg::ADDR_MON_ON);
   wire hit_status = (i_avs_address == smst_pkg::ADDR_STATUS);
   wire hit_mask = (i_avs_address == smst_pkg::ADDR_MASK);
   wire [15:0] lane_mask = {{8{i_avs_byteenable[1]}},
      {8{i_avs_byteenable[0]}}};
   wire [15:0] wmask = lane_mask & smst_pkg::LIVE_BITS; // No 6:3
   wire [15:0] wdata = i_avs_writedata[15:0];

   // One wait state per access, then the answer cycle
   always_comb begin
      case (state_r)
         smst_pkg::SMST_IDLE: begin
            state_nxt = req ? smst_pkg::SMST_ANSWER : smst_pkg::SMST_IDLE;
         end
         default: begin
            state_nxt = smst_pkg::SMST_IDLE;
         end
      endcase
   end

   // Held high in the first cycle of every request
   assign o_avs_waitrequest = req & ~in_answer;

   // ************************************************************
   // Read mux
   // ************************************************************
   wire [15:0] rd_sel =
      hit_selftest ? (selftest_r & smst_pkg::LIVE_BITS) :
      hit_mon_on ? mon_on_r :
      hit_status ? status_r :
      hit_mask ? mask_r :
      16'h0000;

   // Unmapped addresses read zero
   assign rdata_nxt = rd_take ? {16'h0000, rd_sel} : rdata_r;

   // ************************************************************
   // Register writes
   // ************************************************************
   // Self-test starts and stops under software control
   assign selftest_nxt = (wr_commit & hit_selftest) ?
      ((selftest_r & ~wmask) | (wdata & wmask)) : selftest_r;

   // Per-monitor enables, one bit each
   assign mon_on_nxt = (wr_commit & hit_mon_on) ?
      ((mon_on_r & ~wmask) | (wdata & wmask)) : mon_on_r;

   // Interrupt mask, same layout as status
   assign mask_nxt = (wr_commit & hit_mask) ?
      ((mask_r & ~wmask) | (wdata & wmask)) : mask_r;

   // ************************************************************
   // Channel signals to the injectors
   // ************************************************************
   smst_mon_if mon ();

   assign mon.go = smst_pkg::smst_pack(selftest_r);
   assign mon.on = smst_pkg::smst_pack(mon_on_r);

   smst_injector u_injector (
      .i_clk (i_ref_clk),
      .i_rst_n (rst_n_r),
      .mon (mon.ctrl)
   );

   // ************************************************************
   // Fault flags
   // ************************************************************
   // Flags set only by an enabled monitor, from a test pass or a real trip
   wire [11:0] fault_set_c = mon.on & (mon.pass_evt | trip_f_r);
   wire [15:0] fault_set = smst_pkg::smst_unpack(fault_set_c);
   wire [15:0] fault_clr = (wr_commit & hit_status) ? wmask & wdata :
      16'h0000;

   // Sticky, write one to clear, a new event beats the clear
   assign status_nxt = (status_r & ~fault_clr) | fault_set;

   // ************************************************************
   // State update
   // ************************************************************
   // Control registers reset to all tests and monitors off
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         selftest_r <= smst_pkg::SELFTEST_RST;
         mon_on_r <= smst_pkg::MON_ON_RST;
         mask_r <= smst_pkg::MASK_RST;
      end else begin
         selftest_r <= selftest_nxt;
         mon_on_r <= mon_on_nxt;
         mask_r <= mask_nxt;
      end
   end

   // Status, bus state and read data
   always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         status_r <= smst_pkg::STATUS_RST;
         state_r <= smst_pkg::SMST_IDLE;
         rdata_r <= 32'h00000000;
      end else begin
         status_r <= status_nxt;
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Registered data and flags towards the analog side and software
   assign o_avs_readdata = rdata_r;
   assign o_monitor_on = mon.on;
   assign o_selftest_inject = mon.inject;
   assign o_fault_flags = smst_pkg::smst_pack(status_r);
   assign o_irq = |(status_r & mask_r);

endmodule

`default_nettype wire

/* include/smst_pkg.sv */
// Constants, field layout and helpers for the supply monitor self-test
// control block.
// Assumes a 25 MHz reference clock and a byte-addressed Avalon-MM slave.
//
// How it works
// - Bit 15 runs the analog overvoltage test, only while monitor is on.
// - Bit 14 runs the analog undervoltage test, only while monitor is on.
// - Bit 13 runs the I/O overvoltage test, only while that monitor is on.
// - Bit 12 runs the I/O undervoltage test, only while that monitor is on.
// - Bit 11 runs the digital overvoltage test, only while monitor is on.
// - Bit 10 runs the digital undervoltage test, only while monitor is on.
// - Bit 9 runs the analog oscillation test, only while monitor is on.
// - Bit 8 runs the I/O oscillation test, only while that monitor is on.
// - Bit 7 runs the digital oscillation test, only while monitor is on.
// - Bit 2 runs the ground A open test; pass sets its flag in time.
// - Bit 1 runs the ground B open test; pass sets its flag in time.
// - Bit 0 runs the digital ground open test; pass sets flag in time.
// - Bits 6 to 3 of the test register always read zero.
// - Test register sits at 44h and resets to 0000h.
// - Each monitor has its own enable bit, reset off, one turns it on.

package smst_pkg;

   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int NCH = 12;
   localparam int CNT_W = 12;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] ADDR_SELFTEST = 8'h44;
   localparam logic [7:0] ADDR_MON_ON = 8'h48;
   localparam logic [7:0] ADDR_STATUS = 8'h4C;
   localparam logic [7:0] ADDR_MASK = 8'h50;

   // ************************************************************
   // Reset values and live bits
   // ************************************************************
   localparam logic [15:0] SELFTEST_RST = 16'h0000;
   localparam logic [15:0] MON_ON_RST = 16'h0000;
   localparam logic [15:0] STATUS_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] LIVE_BITS = 16'hFF87;

   // ************************************************************
   // Field positions (same in all four registers)
   // ************************************************************
   localparam int BIT_ANA_OV = 15;
   localparam int BIT_DIG_OSC = 7;
   localparam int BIT_RSVD_HI = 6;
   localparam int BIT_RSVD_LO = 3;
   localparam int BIT_GND_A = 2;
   localparam int BIT_DIG_GND = 0;
   localparam int NGND = 3;

   // ************************************************************
   // Propagation times
   // ************************************************************
   localparam int CLK_PERIOD_NS = 40;
   localparam int PROP_SUPPLY_NS = 10000;
   localparam int PROP_OPEN_NS = 20000;
   localparam logic [CNT_W-1:0] PROP_SUPPLY_CYC =
      CNT_W'(PROP_SUPPLY_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] PROP_OPEN_CYC =
      CNT_W'(PROP_OPEN_NS / CLK_PERIOD_NS);

   // ************************************************************
   // Bus answer states
   // ************************************************************
   typedef enum logic {SMST_IDLE, SMST_ANSWER} smst_bus_state_t;

   // Register layout to channel vector (grounds in 2:0)
   function automatic logic [NCH-1:0] smst_pack(input logic [15:0] w);
      smst_pack = {w[BIT_ANA_OV:BIT_DIG_OSC], w[BIT_GND_A:BIT_DIG_GND]};
   endfunction

   // Channel vector to register layout, reserved bits zero
   function automatic logic [15:0] smst_unpack(input logic [NCH-1:0] c);
      smst_unpack = {c[NCH-1:NGND], 4'h0, c[NGND-1:0]};
   endfunction

endpackage

/* include/smst_mon_if.sv */
// Interface between the register side and the per-channel injectors.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/10ps
`default_nettype none

interface smst_mon_if;
   logic [smst_pkg::NCH-1:0] go;
   logic [smst_pkg::NCH-1:0] on;
   logic [smst_pkg::NCH-1:0] inject;
   logic [smst_pkg::NCH-1:0] pass_evt;

   modport ctrl (output go, output on, input inject, input pass_evt);
   modport inj (input go, input on, output inject, output pass_evt);
endinterface

`default_nettype wire

/* hdl/smst_injector.sv */
// Per-channel self-test injection and propagation timers.
// Assumes go and on come from registers on the same clock.
`timescale 1ns/10ps
`default_nettype none

module smst_injector (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Channel signals
   smst_mon_if.inj mon
);

   // ************************************************************
   // One timer per channel
   // ************************************************************
   genvar k;
   generate
      for (k = 0; k < smst_pkg::NCH; k++) begin : g_ch
         localparam logic [smst_pkg::CNT_W-1:0] LIM =
            (k < smst_pkg::NGND) ? smst_pkg::PROP_OPEN_CYC :
            smst_pkg::PROP_SUPPLY_CYC;
         logic [smst_pkg::CNT_W-1:0] cnt_r;
         logic inj_r;
         logic evt_r;
         wire run = mon.go[k] & mon.on[k]; // Test bit gated by enable
         wire at_end = (cnt_r == LIM - 1'b1);

         // Counts while the test runs, pulses once at the limit
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               cnt_r <= '0;
               inj_r <= 1'b0;
               evt_r <= 1'b0;
            end else begin
               inj_r <= run;
               evt_r <= run & at_end; // Pass
               if (!run) begin
                  cnt_r <= '0;
               end else if (cnt_r != LIM) begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
         end

         assign mon.inject[k] = inj_r;
         assign mon.pass_evt[k] = evt_r;
      end
   endgenerate

endmodule

`default_nettype wire

/* verif/smst_asserts.sv */
// Checker for the self-test control block, bound to its top module.
// Assumes trip inputs stay low while self-test timing is watched.
`timescale 1ns/10ps
`default_nettype none

module smst_asserts (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   // Bus side
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Monitor side
   input wire logic [11:0] o_monitor_on,
   input wire logic [11:0] o_selftest_inject,
   input wire logic [11:0] o_fault_flags,
   input wire logic o_irq
);
   localparam int LIM_SUP = 250;
   localparam int LIM_GND = 500;
   logic [9:0] run_sup_r;
   logic [9:0] run_gnd_r;
   wire logic req = i_avs_read | i_avs_write;
   wire logic ack = req & ~o_avs_waitrequest;
   wire logic on_wr = ack & i_avs_write & (i_avs_address == 8'h48);
   wire logic [9:0] run_sup_nxt = !o_selftest_inject[11] ? 10'h000 :
      (run_sup_r == 10'h3FF) ? run_sup_r : run_sup_r + 10'h001;
   wire logic [9:0] run_gnd_nxt = !o_selftest_inject[2] ? 10'h000 :
      (run_gnd_r == 10'h3FF) ? run_gnd_r : run_gnd_r + 10'h001;

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   // Cycles each watched injection has stood
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         run_sup_r <= 10'h000;
         run_gnd_r <= 10'h000;
      end else begin
         run_sup_r <= run_sup_nxt;
         run_gnd_r <= run_gnd_nxt;
      end
   end

   // ************************************************************
   // Properties
   // ************************************************************
   property p_inject_needs_on;
      (o_selftest_inject & ~$past(o_monitor_on)) == 12'h000;
   endproperty
   a_inject_needs_on: assert property (p_inject_needs_on)
      else $error("inject without monitor on");
   property p_sup_pass;
      run_sup_r == LIM_SUP |-> o_fault_flags[11];
   endproperty
   a_sup_pass: assert property (p_sup_pass)
      else $error("supply test flag late");
   property p_sup_early;
      $rose(o_fault_flags[11]) && run_sup_r != 10'h000 |->
         run_sup_r == LIM_SUP;
   endproperty
   a_sup_early: assert property (p_sup_early)
      else $error("supply test flag early");
   property p_gnd_pass;
      run_gnd_r == LIM_GND |-> o_fault_flags[2];
   endproperty
   a_gnd_pass: assert property (p_gnd_pass)
      else $error("ground test flag late");
   property p_on_change;
      !$stable(o_monitor_on) |-> $past(on_wr);
   endproperty
   a_on_change: assert property (p_on_change)
      else $error("monitor enables moved without write");
   property p_rsvd_read;
      ack && i_avs_read |-> o_avs_readdata[31:16] == 16'h0000 &&
         o_avs_readdata[6:3] == 4'h0;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved read bits set");
   property p_wait_one;
      req && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest held too long");
   property p_wait_again;
      ack |=> !req || o_avs_waitrequest;
   endproperty
   a_wait_again: assert property (p_wait_again)
      else $error("second request not waited");
   property p_irq_cause;
      o_irq |-> (o_fault_flags != 12'h000);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without flag");

   // Main scenarios reached
   c_sup_pass: cover property (run_sup_r == LIM_SUP);
   c_gnd_pass: cover property (run_gnd_r == LIM_GND);
   c_irq: cover property (o_irq);
endmodule

bind smst_top smst_asserts u_chk (
   .i_ref_clk(i_ref_clk),
   .i_nrst(i_nrst),
   .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest),
   .o_monitor_on(o_monitor_on),
   .o_selftest_inject(o_selftest_inject),
   .o_fault_flags(o_fault_flags),
   .o_irq(o_irq)
);

`default_nettype wire

/* verif/test_supply_monitor_selftest_control.sv */
// Self-checking bench for the self-test control block.
// Assumes one wait state per bus access and trip inputs held low.
`timescale 1ns/10ps
`default_nettype none

`define SMST_CHK(act, exp) \
   begin \
      n_compared++; \
      if ((act) !== (exp)) begin \
         mismatches++; \
         $display("FAIL t=%0t got %0h exp %0h", $time, act, exp); \
      end \
   end

module test_supply_monitor_selftest_control;
   logic clk;
   logic nrst;
   logic [7:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [11:0] trip;
   logic [31:0] got;
   wire logic [31:0] rdata;
   wire logic waitreq;
   wire logic [11:0] mon_on;
   wire logic [11:0] inj;
   wire logic [11:0] flags;
   wire logic irq;
   int mismatches;
   int n_compared;

   smst_top dut (
      .i_ref_clk(clk), .i_nrst(nrst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_monitor_trip(trip),
      .o_monitor_on(mon_on), .o_selftest_inject(inj),
      .o_fault_flags(flags), .o_irq(irq)
   );

   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      // Hold the request until waitrequest is seen low at a rising edge
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, got);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, got);
      `SMST_CHK(got, e);
   endtask

   task automatic pins(input logic [11:0] f, input logic [11:0] i,
                       input logic q);
      @(negedge clk);
      `SMST_CHK(flags, f);
      `SMST_CHK(inj, i);
      `SMST_CHK(irq, q);
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Watchdog
   initial begin
      repeat (4000) @(posedge clk);
      mismatches++;
      $display("FAIL t=%0t watchdog timeout", $time);
      report_and_stop;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      nrst = 1'b0;
      addr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      be = 4'hF;
      trip = 12'h000;
      mismatches = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(8'h44, 32'h0);
      rd_chk(8'h48, 32'h0);
      rd_chk(8'h4C, 32'h0);
      rd_chk(8'h50, 32'h0);
      // Reserved bits and an unmapped place
      wr32(8'h44, 32'hFFFF_FFFF);
      rd_chk(8'h44, 32'h0000_FF87);
      wr32(8'h60, 32'h0000_FFFF);
      rd_chk(8'h60, 32'h0);
      // Tests asked for while every monitor is off
      repeat (600) @(posedge clk);
      pins(12'h000, 12'h000, 1'b0);
      `SMST_CHK(mon_on, 12'h000);
      // Monitors on: supply tests pass first, ground later
      wr32(8'h48, 32'h0000_FFFF);
      repeat (245) @(posedge clk);
      pins(12'h000, 12'hFFF, 1'b0);
      `SMST_CHK(mon_on, 12'hFFF);
      repeat (10) @(posedge clk);
      @(negedge clk);
      `SMST_CHK(flags[11:9], 3'b111);
      `SMST_CHK(flags[8:6], 3'b111);
      `SMST_CHK(flags[5:3], 3'b111);
      `SMST_CHK(flags[2:0], 3'b000);
      repeat (250) @(posedge clk);
      @(negedge clk);
      `SMST_CHK(flags[2:0], 3'b111);
      rd_chk(8'h48, 32'h0000_FF87);
      rd_chk(8'h4C, 32'h0000_FF87);
      // Interrupt unmasked, then cleared with the other flags still masked
      wr32(8'h50, 32'h0000_8000);
      pins(12'hFFF, 12'hFFF, 1'b1);
      wr32(8'h4C, 32'h0000_8000);
      pins(12'h7FF, 12'hFFF, 1'b0);
      rd_chk(8'h4C, 32'h0000_7F87);
      // Monitor switched off stops its injection one edge later
      wr32(8'h48, 32'h0000_7FFF);
      @(posedge clk);
      pins(12'h7FF, 12'h7FF, 1'b0);
      `SMST_CHK(mon_on, 12'h7FF);
      report_and_stop;
   end
endmodule

`default_nettype wire
